// ==== esx_pkg.sv ====
package esx_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ESX_ADDR_XRAM_PAGE_CONTROL = 8'h85;
    localparam logic [7:0] ESX_ADDR_SYSTEM_CONFIG     = 8'hbf;
    localparam logic [7:0] ESX_ADDR_PORT_FOUR         = 8'hd8;

    // field positions
    localparam int ESX_WDR_BIT      = 7;
    localparam int ESX_XRAM_EN_BIT  = 1;
    localparam int ESX_LSI_BIT      = 0;
    localparam int ESX_PAGE_LSB     = 0;

    // values after reset, and the reserved page
    localparam logic [1:0] ESX_PAGE_RST    = 2'h0;
    localparam logic       ESX_XRAM_EN_RST = 1'b1;
    localparam logic       ESX_LSI_RST     = 1'b0;
    localparam logic       ESX_WDR_RST     = 1'b0;
    localparam logic [3:0] ESX_P4_RST      = 4'hf;
    localparam logic [1:0] ESX_PAGE_RESERVED = 2'h3;

    // memory sizes
    localparam int ESX_IRAM_BYTES = 256;
    localparam int ESX_XRAM_BYTES = 768;
    localparam int ESX_P4_PINS    = 4;

    // machine cycle sequencing, counted in oscillator clocks
    localparam logic [3:0] ESX_MC_LAST      = 4'hb;
    localparam logic [3:0] ESX_ALE_LEN      = 4'h2;
    localparam logic [3:0] ESX_ALE_PERIOD   = 4'h6;
    localparam logic [3:0] ESX_STB_FIRST    = 4'h3;
    localparam logic [3:0] ESX_STB_LAST     = 4'h8;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       indirect;
        logic       wr;
        logic       rd;
    } esx_mem_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        via_ri;
        logic        wr;
        logic        rd;
    } esx_xreq_t;

    typedef enum logic [1:0] {XS_IDLE, XS_WAIT, XS_RUN} esx_xstate_t;

endpackage : esx_pkg

// ==== ext_sfr_xram_port_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - direct accesses to 0x80-0xff reach registers; indirect ones never do
// - lower 128 RAM bytes reachable by direct and indirect access
// - upper 128 RAM bytes reachable by indirect access only
// - 768 bytes expanded RAM at external data 0x0000-0x02ff via external moves
// - xram_enable maps the expanded RAM in; resets to 1
// - page select forms bits 9:8 of 8-bit indirect external moves
// - page select is read/write and resets to page zero
// - watchdog reset sets watchdog_reset_flag; other resets clear it
// - latch_strobe_inhibit suppresses the address latch strobe outside external access; resets to 0
// - inhibit stops the free running sixth-rate strobe
// - pins independent; input only while latch holds 1 and driver off
// - ports 1,2,3 with latch 1 weakly pulled high
// - port 0 open drain; latch 1 floats the pin
// - port 0, port 2, port 3 bits 6,7 are GPIO outside external access
// - port_four at 0xd8, bit addressable, four pins like port 1
// - port_four bits 3:0 drive pins, read/write, reset to 1
// - port 2 carries address bits 15:8 during external access
// - port 0 carries multiplexed low address and data during external access
// - port 3 bits 6 and 7 are active-low write and read strobes
// - port 3 bits 2 and 3 are active-low external interrupt inputs
// - machine cycle is twelve oscillator clocks
module ext_sfr_xram_port_ctrl
    import esx_pkg::*;
#(
    parameter int XRAM_BYTES = ESX_XRAM_BYTES
)
(
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         wdt_overflow,
    input  wire esx_mem_req_t mem_req,
    output logic              mem_ack,
    output logic              sfr_hit,
    output logic [7:0]        mem_rdata,
    input  wire logic [7:0]   bit_addr,
    input  wire logic         bit_wr,
    input  wire logic         bit_rd,
    input  wire logic         bit_wdata,
    output logic              bit_hit,
    output logic              bit_rdata,
    input  wire esx_xreq_t    xreq,
    output logic              xready,
    output logic              xack,
    output logic [7:0]        xrdata,
    input  wire logic [7:0]   p0_latch,
    input  wire logic [7:0]   p1_latch,
    input  wire logic [7:0]   p2_latch,
    input  wire logic [7:0]   p3_latch,
    input  wire logic [7:0]   p0_in,
    input  wire logic [7:0]   p1_in,
    input  wire logic [7:0]   p2_in,
    input  wire logic [7:0]   p3_in,
    input  wire logic [3:0]   p4_in,
    output logic [7:0]        p0_out,
    output logic [7:0]        p0_oe,
    output logic [7:0]        p1_out,
    output logic [7:0]        p1_oe,
    output logic [7:0]        p1_pullup_en,
    output logic [7:0]        p2_out,
    output logic [7:0]        p2_oe,
    output logic [7:0]        p2_pullup_en,
    output logic [7:0]        p3_out,
    output logic [7:0]        p3_oe,
    output logic [7:0]        p3_pullup_en,
    output logic [3:0]        p4_out,
    output logic [3:0]        p4_oe,
    output logic [3:0]        p4_pullup_en,
    output logic [35:0]       pin_sampled,
    output logic              ext_interrupt_zero_n,
    output logic              ext_interrupt_one_n,
    output logic              address_latch_strobe,
    output logic [1:0]        xram_page_select,
    output logic              xram_enable,
    output logic              latch_strobe_inhibit,
    output logic              watchdog_reset_flag
);

    if (XRAM_BYTES <= 0 || XRAM_BYTES > ESX_XRAM_BYTES || (XRAM_BYTES % 256) != 0)
    begin : g_bad_size
        $error("XRAM_BYTES must be a multiple of 256 up to 768");
    end

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0]  iram [0:ESX_IRAM_BYTES-1];
    logic [7:0]  xram [0:XRAM_BYTES-1];
    logic [3:0]  port_four;
    logic [3:0]  mc_phase;
    esx_xstate_t xstate;
    logic [15:0] xaddr_q;
    logic [7:0]  xwdata_q;
    logic        xwr_q;
    logic [35:0] pin_meta;

    function automatic logic [15:0] xram_eff(input esx_xreq_t r, input logic [1:0] pg);
        xram_eff = r.via_ri ? {6'h00, pg, r.addr[7:0]} : r.addr;
    endfunction : xram_eff

    // ------------------------------------------------------------------
    // internal data space decode
    // ------------------------------------------------------------------
    wire        mem_go     = mem_req.rd | mem_req.wr;
    wire        mem_is_sfr = mem_req.addr[7] & ~mem_req.indirect;
    wire        sel_page   = mem_is_sfr & (mem_req.addr == ESX_ADDR_XRAM_PAGE_CONTROL);
    wire        sel_conf   = mem_is_sfr & (mem_req.addr == ESX_ADDR_SYSTEM_CONFIG);
    wire        sel_p4     = mem_is_sfr & (mem_req.addr == ESX_ADDR_PORT_FOUR);
    wire        sel_any    = sel_page | sel_conf | sel_p4;
    // unused bits read as zero so software sees a stable value
    wire [7:0]  rd_page    = {6'h00, xram_page_select};
    wire [7:0]  rd_conf    = {watchdog_reset_flag, 5'h00, xram_enable, latch_strobe_inhibit};
    wire [7:0]  rd_p4      = {4'h0, port_four};
    wire [7:0]  sfr_rd_val = sel_page ? rd_page : sel_conf ? rd_conf : sel_p4 ? rd_p4 : 8'h00;
    wire        ram_wr     = mem_req.wr & ~mem_is_sfr;

    wire        bit_is_p4  = (bit_addr[7:3] == ESX_ADDR_PORT_FOUR[7:3])
                           & (bit_addr[2:0] < 3'(ESX_P4_PINS));
    wire [1:0]  bit_idx    = bit_addr[1:0];

    // ------------------------------------------------------------------
    // external data move decode
    // ------------------------------------------------------------------
    wire [15:0] xeff       = xram_eff(xreq, xram_page_select);
    wire        xgo        = (xreq.rd | xreq.wr) & (xstate == XS_IDLE);
    wire        page_ok    = ~xreq.via_ri | (xram_page_select != ESX_PAGE_RESERVED);
    wire        xinternal  = xram_enable & page_ok & (xeff < 16'(XRAM_BYTES));
    wire        xrun       = (xstate == XS_RUN);
    wire        in_ale     = mc_phase < ESX_ALE_LEN;
    wire        in_stb     = (mc_phase >= ESX_STB_FIRST) & (mc_phase <= ESX_STB_LAST);
    wire        free_ale   = (mc_phase < ESX_ALE_LEN)
                           | ((mc_phase >= ESX_ALE_PERIOD) & (mc_phase < ESX_ALE_PERIOD + ESX_ALE_LEN));

    assign xready = (xstate == XS_IDLE);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // a watchdog overflow reinitialises like a reset but leaves the flag set;
    // that branch also wins over a software clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xram_page_select     <= ESX_PAGE_RST;
            xram_enable          <= ESX_XRAM_EN_RST;
            latch_strobe_inhibit <= ESX_LSI_RST;
            watchdog_reset_flag  <= ESX_WDR_RST;
            port_four            <= ESX_P4_RST;
        end
        else if (wdt_overflow)
        begin
            xram_page_select     <= ESX_PAGE_RST;
            xram_enable          <= ESX_XRAM_EN_RST;
            latch_strobe_inhibit <= ESX_LSI_RST;
            watchdog_reset_flag  <= 1'b1;
            port_four            <= ESX_P4_RST;
        end
        else
        begin
            if (mem_req.wr && sel_page)
                xram_page_select <= mem_req.wdata[ESX_PAGE_LSB +: 2];
            if (mem_req.wr && sel_conf)
            begin
                watchdog_reset_flag  <= mem_req.wdata[ESX_WDR_BIT];
                xram_enable          <= mem_req.wdata[ESX_XRAM_EN_BIT];
                latch_strobe_inhibit <= mem_req.wdata[ESX_LSI_BIT];
            end
            if (mem_req.wr && sel_p4)
                port_four <= mem_req.wdata[3:0];
            else if (bit_wr && bit_is_p4)
                port_four[bit_idx] <= bit_wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (ram_wr)
            iram[mem_req.addr] <= mem_req.wdata;
        if (xgo && xinternal && xreq.wr)
            xram[xeff[9:0]] <= xreq.wdata;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mem_ack   <= 1'b0;
            sfr_hit   <= 1'b0;
            mem_rdata <= 8'h00;
            bit_hit   <= 1'b0;
            bit_rdata <= 1'b0;
        end
        else
        begin
            mem_ack   <= mem_go;
            sfr_hit   <= mem_go & sel_any;
            if (mem_req.rd)
                mem_rdata <= mem_is_sfr ? sfr_rd_val : iram[mem_req.addr];
            bit_hit   <= (bit_rd | bit_wr) & bit_is_p4;
            if (bit_rd)
                bit_rdata <= bit_is_p4 & port_four[bit_idx];
        end
    end

    // ------------------------------------------------------------------
    // machine cycle phase and external bus sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            mc_phase <= 4'h0;
        else if (mc_phase == ESX_MC_LAST)
            mc_phase <= 4'h0;
        else
            mc_phase <= mc_phase + 4'h1;
    end

    // an external move waits for a machine cycle boundary, then takes one whole cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xstate   <= XS_IDLE;
            xaddr_q  <= 16'h0000;
            xwdata_q <= 8'h00;
            xwr_q    <= 1'b0;
            xack     <= 1'b0;
            xrdata   <= 8'h00;
        end
        else
        begin
            xack <= 1'b0;
            case (xstate)
                XS_IDLE:
                begin
                    if (xgo && xinternal)
                    begin
                        xack <= 1'b1;
                        if (xreq.rd)
                            xrdata <= xram[xeff[9:0]];
                    end
                    else if (xgo)
                    begin
                        xaddr_q  <= xeff;
                        xwdata_q <= xreq.wdata;
                        xwr_q    <= xreq.wr;
                        xstate   <= (mc_phase == ESX_MC_LAST) ? XS_RUN : XS_WAIT;
                    end
                end
                XS_WAIT:
                begin
                    if (mc_phase == ESX_MC_LAST)
                        xstate <= XS_RUN;
                end
                XS_RUN:
                begin
                    if (!xwr_q && mc_phase == ESX_STB_LAST)
                        xrdata <= pin_sampled[7:0];
                    if (mc_phase == ESX_MC_LAST)
                    begin
                        xstate <= XS_IDLE;
                        xack   <= 1'b1;
                    end
                end
                default:
                    xstate <= XS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    // quasi pins drive low only while the latch is 0; a latch of 1 leaves the weak pull-up
    wire [7:0] next_p0_out = !xrun ? 8'h00 : in_stb ? xwdata_q : xaddr_q[7:0];
    wire [7:0] next_p0_oe  = !xrun ? ~p0_latch :
                             (in_ale || (xwr_q && mc_phase >= ESX_STB_FIRST)) ? 8'hff : 8'h00;
    wire [7:0] next_p2_out = xrun ? xaddr_q[15:8] : 8'h00;
    wire [7:0] next_p2_oe  = xrun ? 8'hff : ~p2_latch;
    wire       wr_stb_n    = ~(xrun & xwr_q & in_stb);
    wire       rd_stb_n    = ~(xrun & ~xwr_q & in_stb);
    wire [7:0] next_p3_out = xrun ? {rd_stb_n, wr_stb_n, 6'h00} : 8'h00;
    wire [7:0] next_p3_oe  = xrun ? {2'b11, ~p3_latch[5:0]} : ~p3_latch;
    wire [7:0] next_p3_pu  = xrun ? {2'b00, p3_latch[5:0]} : p3_latch;
    wire       next_ale    = (~latch_strobe_inhibit & free_ale) | (xrun & in_ale);

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            p0_out <= 8'h00;
            p0_oe  <= 8'h00;
            p1_out <= 8'h00;
            p1_oe  <= 8'h00;
            p1_pullup_en <= 8'hff;
            p2_out <= 8'h00;
            p2_oe  <= 8'h00;
            p2_pullup_en <= 8'hff;
            p3_out <= 8'h00;
            p3_oe  <= 8'h00;
            p3_pullup_en <= 8'hff;
            p4_out <= 4'h0;
            p4_oe  <= 4'h0;
            p4_pullup_en <= 4'hf;
            address_latch_strobe <= 1'b0;
        end
        else
        begin
            p0_out <= next_p0_out;
            p0_oe  <= next_p0_oe;
            p1_out <= 8'h00;
            p1_oe  <= ~p1_latch;
            p1_pullup_en <= p1_latch;
            p2_out <= next_p2_out;
            p2_oe  <= next_p2_oe;
            p2_pullup_en <= xrun ? 8'h00 : p2_latch;
            p3_out <= next_p3_out;
            p3_oe  <= next_p3_oe;
            p3_pullup_en <= next_p3_pu;
            p4_out <= 4'h0;
            p4_oe  <= ~port_four;
            p4_pullup_en <= port_four;
            address_latch_strobe <= next_ale;
        end
    end

    // ------------------------------------------------------------------
    // pin sampling, two flops before any use
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta    <= '1;
            pin_sampled <= '1;
        end
        else
        begin
            pin_meta    <= {p4_in, p3_in, p2_in, p1_in, p0_in};
            pin_sampled <= pin_meta;
        end
    end

    assign ext_interrupt_zero_n = pin_sampled[26];
    assign ext_interrupt_one_n  = pin_sampled[27];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_ext_start;
        (xstate == XS_RUN) && (mc_phase == 4'h0);
    endsequence

    sequence s_ext_strobe_wr;
        (!p3_out[6] && p3_oe[6])[*6];
    endsequence

    // direct write, an idle cycle, then an indirect read of the same lower byte
    sequence s_low_write_then_read;
        mem_req.wr && !mem_req.indirect && !mem_req.addr[7] ##1 !mem_req.wr
        ##1 mem_req.rd && mem_req.indirect && mem_req.addr == $past(mem_req.addr, 2);
    endsequence

    AST_SFR_NO_INDIRECT: assert property (mem_go && mem_req.indirect |=> !sfr_hit)
        else $error("indirect access hit a register");
    AST_LOW_RAM_BOTH: assert property (s_low_write_then_read |=> mem_rdata == $past(mem_req.wdata, 3))
        else $error("lower RAM not shared by direct and indirect access");
    AST_UPPER_INDIRECT: assert property (
        mem_req.rd && mem_req.indirect && mem_req.addr[7] |=> mem_ack && !sfr_hit)
        else $error("upper RAM indirect read reached registers");
    AST_XRAM_INTERNAL: assert property (xgo && xinternal |=> xack && xstate == XS_IDLE)
        else $error("expanded RAM move not answered next cycle");
    AST_PAGE_RESERVED: assert property (
        xgo && xreq.via_ri && xram_page_select == ESX_PAGE_RESERVED |=> xstate != XS_IDLE)
        else $error("reserved page did not go to the external bus");
    AST_WDT_FLAG: assert property (
        wdt_overflow |=> watchdog_reset_flag && xram_page_select == ESX_PAGE_RST && xram_enable)
        else $error("watchdog reset did not set flag and reinitialise");
    AST_ALE_INHIBIT: assert property (latch_strobe_inhibit && !xrun |=> !address_latch_strobe)
        else $error("strobe not suppressed while inhibited");
    // inhibit must stay clear over both strobe phases, a write in between may legally cut the pulse
    AST_ALE_RATE: assert property (
        !latch_strobe_inhibit && mc_phase == 4'h6 ##1 !latch_strobe_inhibit
        |-> address_latch_strobe ##1 address_latch_strobe ##1 !address_latch_strobe)
        else $error("free running strobe pattern wrong");
    AST_P4_DRIVE: assert property (
        $changed(port_four) |=> p4_oe == ~$past(port_four) && p4_pullup_en == $past(port_four))
        else $error("port_four pins do not follow latch");
    AST_P0_OPEN_DRAIN: assert property (!xrun |=> p0_out == 8'h00 && p0_oe == ~$past(p0_latch))
        else $error("port 0 not open drain");
    AST_EXT_ADDR: assert property (
        s_ext_start |=> p2_out == xaddr_q[15:8] && p0_out == xaddr_q[7:0] && p0_oe == 8'hff)
        else $error("external address not on ports");
    AST_EXT_WR_STROBE: assert property (xrun && xwr_q && mc_phase == 4'h3 |=> s_ext_strobe_wr)
        else $error("write strobe not low for six clocks");
    AST_MC_PERIOD: assert property (mc_phase == 4'h0 |-> ##11 mc_phase == ESX_MC_LAST ##1 mc_phase == 4'h0)
        else $error("machine cycle not twelve clocks");
    AST_INT_PIN: assert property (##2 ext_interrupt_zero_n == $past(p3_in[2], 2))
        else $error("interrupt input not synchronised");

endmodule : ext_sfr_xram_port_ctrl

`default_nettype wire

// ==== esx_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module esx_core_model
    import esx_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        xready,
    output var esx_mem_req_t mem_req,
    output var esx_xreq_t    xreq
);
    initial
    begin
        mem_req = '0;
        xreq    = '0;
    end

    // one byte move, held over exactly one rising edge
    task automatic move(input logic [7:0] a, input logic ind, input logic w, input logic [7:0] d);
        @(negedge sys_clk);
        mem_req = '{a, d, ind, w, ~w};
        @(negedge sys_clk);
        mem_req = '0;
    endtask : move

    // offered only while the sequencer is idle, or it would be dropped
    task automatic xmove(input logic [15:0] a, input logic ri, input logic w, input logic [7:0] d);
        @(negedge sys_clk);
        while (!xready)
            @(negedge sys_clk);
        xreq = '{a, d, ri, w, ~w};
        @(negedge sys_clk);
        xreq = '0;
    endtask : xmove
endmodule : esx_core_model

`default_nettype wire

// ==== ext_sfr_xram_port_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module ext_sfr_xram_port_ctrl_tb
    import esx_pkg::*;
;
    logic sys_clk = 0, reset_n = 0, wdt_overflow = 0, bit_wr = 0, bit_rd = 0, bit_wdata = 0;
    logic [7:0] bit_addr = 0, p0_latch = 8'hff, p1_latch = 8'hff, p2_latch = 8'hff, p3_latch = 8'hff;
    logic [7:0] p0_in = 8'hff, p1_in = 8'hff, p2_in = 8'hff, p3_in = 8'hff;
    logic [3:0] p4_in = 4'hf;
    esx_mem_req_t mem_req;
    esx_xreq_t xreq;
    logic mem_ack, sfr_hit, bit_hit, bit_rdata, xready, xack, ext_interrupt_zero_n, ext_interrupt_one_n;
    logic address_latch_strobe, xram_enable, latch_strobe_inhibit, watchdog_reset_flag;
    logic [7:0] mem_rdata, xrdata, p0_out, p0_oe, p1_out, p1_oe, p1_pullup_en, p2_out, p2_oe, p2_pullup_en;
    logic [7:0] p3_out, p3_oe, p3_pullup_en;
    logic [3:0] p4_out, p4_oe, p4_pullup_en;
    logic [35:0] pin_sampled;
    logic [1:0] xram_page_select;
    int err_count = 0, num_checks = 0;

    always #5 sys_clk = ~sys_clk;

    esx_core_model core (.sys_clk, .xready, .mem_req, .xreq);

    ext_sfr_xram_port_ctrl dut (.sys_clk, .reset_n, .wdt_overflow, .mem_req, .mem_ack, .sfr_hit, .mem_rdata,
        .bit_addr, .bit_wr, .bit_rd, .bit_wdata, .bit_hit, .bit_rdata, .xreq, .xready, .xack, .xrdata,
        .p0_latch, .p1_latch, .p2_latch, .p3_latch, .p0_in, .p1_in, .p2_in, .p3_in, .p4_in,
        .p0_out, .p0_oe, .p1_out, .p1_oe, .p1_pullup_en, .p2_out, .p2_oe, .p2_pullup_en,
        .p3_out, .p3_oe, .p3_pullup_en, .p4_out, .p4_oe, .p4_pullup_en, .pin_sampled,
        .ext_interrupt_zero_n, .ext_interrupt_one_n, .address_latch_strobe, .xram_page_select,
        .xram_enable, .latch_strobe_inhibit, .watchdog_reset_flag);

    // ------------------------------------------------------------------
    // checking and access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // for a read, d is the expected data
    task automatic rw(input logic [7:0] a, input logic ind, input logic w, input logic [7:0] d, input logic hit);
        core.move(a, ind, w, d);
        chk({7'h0, mem_ack}, 8'h01);
        chk({7'h0, sfr_hit}, {7'h0, hit});
        if (!w)
            chk(mem_rdata, d);
    endtask : rw

    task automatic xm(input logic [15:0] a, input logic ri, input logic w, input logic [7:0] d);
        int n;
        core.xmove(a, ri, w, d);
        n = 0;
        // a move on the pins answers only after a whole machine cycle
        while (!xack && n < 30)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk({7'h0, xack}, 8'h01);
        if (!w)
            chk(xrdata, d);
    endtask : xm

    // any twelve consecutive phases hold two strobe pulses of two clocks each, four strobe-high clocks
    task automatic ale(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        repeat (12)
        begin
            @(negedge sys_clk);
            n = n + {7'h0, address_latch_strobe};
        end
        chk(n, exp);
    endtask : ale

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(negedge sys_clk);
        reset_n = 1;
        rw(ESX_ADDR_XRAM_PAGE_CONTROL, 0, 0, 8'h00, 1);
        rw(ESX_ADDR_SYSTEM_CONFIG, 0, 0, 8'h02, 1);
        rw(ESX_ADDR_PORT_FOUR, 0, 0, 8'h0f, 1);
        rw(ESX_ADDR_XRAM_PAGE_CONTROL, 0, 1, 8'hfe, 1);
        rw(ESX_ADDR_XRAM_PAGE_CONTROL, 0, 0, 8'h02, 1);
        done("registers");
        rw(8'h85, 1, 1, 8'h5a, 0);
        rw(8'h85, 1, 0, 8'h5a, 0);
        rw(ESX_ADDR_XRAM_PAGE_CONTROL, 0, 0, 8'h02, 1);
        rw(8'h40, 0, 1, 8'hc3, 0);
        rw(8'h40, 1, 0, 8'hc3, 0);
        rw(8'h90, 0, 0, 8'h00, 0);
        done("address map");
        xm(16'h02ff, 0, 1, 8'ha5);
        xm(16'h00ff, 1, 0, 8'ha5);
        xm(16'h0000, 0, 1, 8'h3c);
        rw(ESX_ADDR_XRAM_PAGE_CONTROL, 0, 1, 8'h00, 1);
        xm(16'h7700, 1, 0, 8'h3c);
        p0_in = 8'h69;
        rw(ESX_ADDR_XRAM_PAGE_CONTROL, 0, 1, 8'h03, 1);
        xm(16'h0012, 1, 0, 8'h69);
        xm(16'h0400, 0, 1, 8'h96);
        done("expanded ram");
        p0_latch = 8'h3c;
        p1_latch = 8'h0f;
        p3_in = 8'hf7;
        p4_in = 4'h5;
        repeat (3) @(negedge sys_clk);
        chk(p0_oe, 8'hc3);
        chk(p0_out, 8'h00);
        chk(p1_oe, 8'hf0);
        chk(p1_pullup_en, 8'h0f);
        chk({4'h0, p4_pullup_en}, 8'h0f);
        chk({4'h0, pin_sampled[35:32]}, 8'h05);
        chk({6'h0, ext_interrupt_one_n, ext_interrupt_zero_n}, 8'h01);
        bit_addr = 8'hd9;
        bit_wr = 1;
        @(negedge sys_clk);
        bit_wr = 0;
        chk({7'h0, bit_hit}, 8'h01);
        @(negedge sys_clk);
        chk({4'h0, p4_oe}, 8'h02);
        bit_rd = 1;
        @(negedge sys_clk);
        bit_rd = 0;
        chk({6'h0, bit_hit, bit_rdata}, 8'h02);
        rw(ESX_ADDR_PORT_FOUR, 0, 0, 8'h0d, 1);
        done("ports");
        ale(8'h04);
        rw(ESX_ADDR_SYSTEM_CONFIG, 0, 1, 8'h03, 1);
        @(negedge sys_clk);
        ale(8'h00);
        chk({7'h0, latch_strobe_inhibit}, 8'h01);
        done("strobe");
        wdt_overflow = 1;
        @(negedge sys_clk);
        wdt_overflow = 0;
        chk({7'h0, watchdog_reset_flag}, 8'h01);
        rw(ESX_ADDR_SYSTEM_CONFIG, 0, 0, 8'h82, 1);
        rw(ESX_ADDR_PORT_FOUR, 0, 0, 8'h0f, 1);
        reset_n = 0;
        @(negedge sys_clk);
        reset_n = 1;
        rw(ESX_ADDR_SYSTEM_CONFIG, 0, 0, 8'h02, 1);
        done("watchdog");
        summarize();
    end

    // the sequence needs some 130 cycles; fifteen times that means a hang
    initial
    begin
        #20000;
        err_count++;
        summarize();
    end
endmodule : ext_sfr_xram_port_ctrl_tb

`default_nettype wire
